//--- hssp_top.v
// Strap sampling and multi-function pin control for the hub pins.
`timescale 1ns/1ps
`include "hssp_defines.vh"
module hssp_top (
    input wire clk_sys_in,
    input wire sys_rst_in,
    input wire power_ctl_polarity_strap_in,
    input wire serial_mode_select_in,
    input wire billboard_enable_pin_in,
    input wire bb_cfg_state_pin0_in,
    input wire bb_cfg_state_pin1_in,
    input wire [3:0] port_power_on_in,
    input wire status_output_enable_in,
    input wire charging_enabled_any_in,
    input wire upstream_hs_connected_in,
    input wire upstream_ss_connected_in,
    input wire upstream_hs_suspended_in,
    input wire reg_bb_enable_in,
    input wire [1:0] reg_bb_cfg_field_in,
    input wire reg_ganged_wr_in,
    input wire reg_ganged_in,
    input wire reg_full_auto_wr_in,
    input wire reg_full_auto_in,
    input wire reg_switch_absent_wr_in,
    input wire reg_switch_absent_in,
    input wire reg_auto_dis_wr_in,
    input wire reg_auto_dis_in,
    output reg [3:0] port_power_switch_out,
    output reg billboard_enable_pin_out,
    output reg billboard_enable_pin_oe_out,
    output reg bb_cfg_state_pin0_out,
    output reg bb_cfg_state_pin0_oe_out,
    output reg bb_cfg_state_pin1_out,
    output reg bb_cfg_state_pin1_oe_out,
    output reg i2c_mode_out,
    output reg billboard_enable_out,
    output reg [1:0] bb_cfg_state_field_out,
    output reg ganged_power_out,
    output reg full_auto_charge_enable_out,
    output reg power_switch_absent_out,
    output reg auto_charge_disable_bit_out
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire pol_s;
    wire mode_s;
    wire billboard_enable_pin_s;
    wire cfg0_s;
    wire cfg1_s;
    wire [4:0] pin_raw;
    wire [4:0] pin_s;
    assign pin_raw = {power_ctl_polarity_strap_in, serial_mode_select_in,
                      billboard_enable_pin_in, bb_cfg_state_pin0_in,
                      bb_cfg_state_pin1_in};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
            hssp_sync u_sync (
                .clk_sys_in(clk_sys_in),
                .sys_rst_in(sys_rst_in),
                .d_in(pin_raw[gi]),
                .q_out(pin_s[gi])
            );
        end
    endgenerate
    assign {pol_s, mode_s, billboard_enable_pin_s, cfg0_s, cfg1_s} = pin_s;

    // ------------------------------------------------------------
    // Sampling sequence
    // ------------------------------------------------------------
    // The synchronisers are flushed for three cycles after release so the
    // straps are caught from settled pin levels, not from reset values.
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [1:0] wait_reg;
    reg pol_reg;
    reg run_reg;
    wire sample_now;
    wire ind_on;
    assign sample_now = (state_reg == `HSSP_ST_SAMPLE) &&
                        (wait_reg == `HSSP_SAMPLE_WAIT);
    assign ind_on = run_reg && !i2c_mode_out && status_output_enable_in;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            `HSSP_ST_RESET: state_next = `HSSP_ST_SAMPLE;
            `HSSP_ST_SAMPLE: if (sample_now) state_next = `HSSP_ST_RUN;
            `HSSP_ST_RUN: state_next = `HSSP_ST_RUN;
            default: state_next = `HSSP_ST_RESET;
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state_reg <= `HSSP_ST_RESET;
            wait_reg <= 2'h0;
            run_reg <= 1'b0;
            pol_reg <= `HSSP_POL_RST;
            i2c_mode_out <= `HSSP_MODE_RST;
            ganged_power_out <= `HSSP_PWR_INDIVIDUAL;
            full_auto_charge_enable_out <= 1'b0;
            power_switch_absent_out <= 1'b0;
            auto_charge_disable_bit_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == `HSSP_ST_SAMPLE && !sample_now)
                wait_reg <= wait_reg + 2'h1;
            // Charging enable is looked at on the sampling edge only, so a
            // later change of it does not re-steer the pin zero strap.
            if (sample_now) begin
                run_reg <= 1'b1;
                pol_reg <= pol_s;
                i2c_mode_out <= mode_s;
                if (mode_s == `HSSP_MODE_SMBUS) begin
                    ganged_power_out <= billboard_enable_pin_s;
                    if (charging_enabled_any_in)
                        full_auto_charge_enable_out <= !cfg0_s;
                    else
                        power_switch_absent_out <= cfg0_s;
                    auto_charge_disable_bit_out <= cfg1_s;
                end
            end else if (run_reg && !i2c_mode_out) begin
                // Host writes override the strapped values afterwards.
                if (reg_ganged_wr_in)
                    ganged_power_out <= reg_ganged_in;
                if (reg_full_auto_wr_in)
                    full_auto_charge_enable_out <= reg_full_auto_in;
                if (reg_switch_absent_wr_in)
                    power_switch_absent_out <= reg_switch_absent_in;
                if (reg_auto_dis_wr_in)
                    auto_charge_disable_bit_out <= reg_auto_dis_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Power switch outputs
    // ------------------------------------------------------------
    // Power switches are held at 0 until sampling is done, since the
    // polarity is unknown before that. A board strapped for active low
    // must keep its switches off by other means during reset.
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            port_power_switch_out <= 4'h0;
        end else if (!run_reg) begin
            port_power_switch_out <= 4'h0;
        end else if (pol_reg == `HSSP_POL_ACTIVE_HIGH) begin
            port_power_switch_out <= port_power_on_in;
        end else begin
            port_power_switch_out <= ~port_power_on_in;
        end
    end

    // ------------------------------------------------------------
    // Multi-function pin drivers
    // ------------------------------------------------------------
    // Enables and levels are registered together, so a pin never shows a
    // stale level in the cycle its driver turns on. A disabled driver
    // also shows 0, so no indicator level leaks out while the pin is an
    // input.
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            billboard_enable_pin_out <= 1'b0;
            billboard_enable_pin_oe_out <= 1'b0;
            bb_cfg_state_pin0_out <= 1'b0;
            bb_cfg_state_pin0_oe_out <= 1'b0;
            bb_cfg_state_pin1_out <= 1'b0;
            bb_cfg_state_pin1_oe_out <= 1'b0;
        end else begin
            billboard_enable_pin_oe_out <= ind_on;
            bb_cfg_state_pin0_oe_out <= ind_on;
            bb_cfg_state_pin1_oe_out <= ind_on;
            billboard_enable_pin_out <= ind_on & upstream_hs_connected_in;
            bb_cfg_state_pin0_out <= ind_on & upstream_ss_connected_in;
            bb_cfg_state_pin1_out <= ind_on & upstream_hs_suspended_in;
        end
    end

    // ------------------------------------------------------------
    // Effective billboard values
    // ------------------------------------------------------------
    // With a host attached the pins are ignored here, since they may be
    // busy as indicator outputs.
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            billboard_enable_out <= 1'b0;
            bb_cfg_state_field_out <= 2'h0;
        end else if (!run_reg) begin
            billboard_enable_out <= 1'b0;
            bb_cfg_state_field_out <= 2'h0;
        end else if (i2c_mode_out) begin
            billboard_enable_out <= billboard_enable_pin_s;
            bb_cfg_state_field_out <= {cfg1_s, cfg0_s};
        end else begin
            billboard_enable_out <= reg_bb_enable_in;
            bb_cfg_state_field_out <= reg_bb_cfg_field_in;
        end
    end
endmodule // hssp_top

//--- hssp_defines.vh
// Constants for the hub strap and status pin block.
`ifndef HSSP_DEFINES_VH
`define HSSP_DEFINES_VH
`define HSSP_NUM_PORTS 4
`define HSSP_MODE_I2C 1'b1
`define HSSP_MODE_SMBUS 1'b0
`define HSSP_POL_ACTIVE_LOW 1'b0
`define HSSP_POL_ACTIVE_HIGH 1'b1
`define HSSP_PWR_INDIVIDUAL 1'b0
`define HSSP_PWR_GANGED 1'b1
`define HSSP_POL_RST 1'b0
`define HSSP_MODE_RST 1'b1
`define HSSP_ST_RESET 2'h0
`define HSSP_ST_SAMPLE 2'h1
`define HSSP_ST_RUN 2'h2
`define HSSP_SAMPLE_WAIT 2'h2
`endif

//--- hssp_sync.v
// Two-flop synchroniser for one asynchronous pin level.
`timescale 1ns/1ps
module hssp_sync (
    input wire clk_sys_in,
    input wire sys_rst_in,
    input wire d_in,
    output reg q_out
);
    reg meta_reg;
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            meta_reg <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule // hssp_sync

//--- hssp_board.sv
// Board model: strap resistors and the hub's shared status pins.
`timescale 1ns/1ps
module hssp_board (
    input logic [4:0] strap_in,
    input logic [2:0] drv_in,
    input logic [2:0] oe_in,
    output logic [4:0] pin_out
);
    // A pin the hub drives shows its level; otherwise the resistor wins.
    assign pin_out = {strap_in[4:3], (oe_in & drv_in) | (~oe_in & strap_in[2:0])};
endmodule // hssp_board

//--- hssp_checker_assertions.sv
// Concurrent checks on the ports of the strap and status pin block.
`timescale 1ns/1ps
module hssp_checker (
    input logic clk_sys_in,
    input logic sys_rst_in,
    input logic [3:0] port_power_on_in,
    input logic [3:0] port_power_switch_out,
    input logic bb_cfg_state_pin0_in,
    input logic bb_cfg_state_pin1_in,
    input logic billboard_enable_pin_in,
    input logic upstream_hs_connected_in,
    input logic upstream_hs_suspended_in,
    input logic reg_ganged_wr_in,
    input logic reg_ganged_in,
    input logic billboard_enable_pin_out,
    input logic billboard_enable_pin_oe_out,
    input logic bb_cfg_state_pin1_out,
    input logic bb_cfg_state_pin1_oe_out,
    input logic i2c_mode_out,
    input logic billboard_enable_out,
    input logic [1:0] bb_cfg_state_field_out,
    input logic ganged_power_out
);
    logic [2:0] cnt_reg;
    logic run;
    // Saturating count of cycles since reset; run marks settled operation.
    always_ff @(posedge clk_sys_in)
        cnt_reg <= sys_rst_in ? 3'h0 : cnt_reg + {2'h0, ~&cnt_reg};
    assign run = &cnt_reg;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    a_pol_follow: assert property (run |-> port_power_switch_out ==
        $past(port_power_on_in) || port_power_switch_out ==
        ~$past(port_power_on_in)) else $error("power switch mismatch");
    a_oe_early: assert property (cnt_reg < 3'h4 |->
        !billboard_enable_pin_oe_out) else $error("pin driven early");
    a_oe_smbus: assert property (billboard_enable_pin_oe_out |->
        !i2c_mode_out) else $error("pin driven in i2c mode");
    a_hs_ind: assert property (billboard_enable_pin_oe_out &&
        $past(billboard_enable_pin_oe_out) |-> billboard_enable_pin_out ==
        $past(upstream_hs_connected_in)) else $error("hs indicator");
    a_susp_ind: assert property (bb_cfg_state_pin1_oe_out &&
        $past(bb_cfg_state_pin1_oe_out) |-> bb_cfg_state_pin1_out ==
        $past(upstream_hs_suspended_in)) else $error("suspend ind");
    a_i2c_field: assert property (run && i2c_mode_out |->
        bb_cfg_state_field_out == {$past(bb_cfg_state_pin1_in, 3),
        $past(bb_cfg_state_pin0_in, 3)}) else $error("i2c field");
    a_i2c_billboard_enable_pin: assert property (run && i2c_mode_out |-> billboard_enable_out
        == $past(billboard_enable_pin_in, 3)) else $error("i2c enable");
    a_gang_write: assert property (run && !i2c_mode_out && reg_ganged_wr_in
        |=> ganged_power_out == $past(reg_ganged_in)) else $error("gang wr");
    a_mode_held: assert property (run |-> $stable(i2c_mode_out))
        else $error("mode changed");
    c_status: cover property (run && billboard_enable_pin_oe_out);
    c_i2c: cover property (run && i2c_mode_out);
    c_write: cover property (run && reg_ganged_wr_in && !i2c_mode_out);
endmodule // hssp_checker
bind hssp_top hssp_checker chk_u (.clk_sys_in, .sys_rst_in, .port_power_on_in,
    .port_power_switch_out, .bb_cfg_state_pin0_in, .bb_cfg_state_pin1_in,
    .billboard_enable_pin_in, .upstream_hs_connected_in,
    .upstream_hs_suspended_in, .reg_ganged_wr_in, .reg_ganged_in,
    .billboard_enable_pin_out, .billboard_enable_pin_oe_out,
    .bb_cfg_state_pin1_out, .bb_cfg_state_pin1_oe_out, .i2c_mode_out,
    .billboard_enable_out, .bb_cfg_state_field_out, .ganged_power_out);

//--- testbench.sv
// Self-checking bench for the strap and status pin block.
`timescale 1ns/1ps
module testbench;
    logic clk_sys_in = 0;
    logic sys_rst_in = 1;
    logic [4:0] strap = 5'h18;
    logic [4:0] pin;
    logic [3:0] req = 4'h0, wr = 4'h0, wd = 4'h0, psw;
    logic [2:0] up = 3'h0, drv, oe;
    logic [1:0] rfld = 2'h2, fld;
    logic sts = 0, chg = 0, rbb = 0, i2c, billboard_enable_pin, gang, fauto, absent, adis;
    int n_mismatch = 0, check_count = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    hssp_board brd_u (.strap_in(strap), .drv_in(drv), .oe_in(oe), .pin_out(pin));
    hssp_top dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .power_ctl_polarity_strap_in(pin[4]), .serial_mode_select_in(pin[3]),
        .billboard_enable_pin_in(pin[2]), .bb_cfg_state_pin0_in(pin[1]),
        .bb_cfg_state_pin1_in(pin[0]), .port_power_on_in(req),
        .status_output_enable_in(sts), .charging_enabled_any_in(chg),
        .upstream_hs_connected_in(up[0]), .upstream_ss_connected_in(up[1]),
        .upstream_hs_suspended_in(up[2]), .reg_bb_enable_in(rbb),
        .reg_bb_cfg_field_in(rfld), .reg_ganged_wr_in(wr[0]),
        .reg_ganged_in(wd[0]), .reg_full_auto_wr_in(wr[1]),
        .reg_full_auto_in(wd[1]), .reg_switch_absent_wr_in(wr[2]),
        .reg_switch_absent_in(wd[2]), .reg_auto_dis_wr_in(wr[3]),
        .reg_auto_dis_in(wd[3]), .port_power_switch_out(psw),
        .billboard_enable_pin_out(drv[2]), .billboard_enable_pin_oe_out(oe[2]),
        .bb_cfg_state_pin0_out(drv[1]), .bb_cfg_state_pin0_oe_out(oe[1]),
        .bb_cfg_state_pin1_out(drv[0]), .bb_cfg_state_pin1_oe_out(oe[0]),
        .i2c_mode_out(i2c), .billboard_enable_out(billboard_enable_pin),
        .bb_cfg_state_field_out(fld), .ganged_power_out(gang),
        .full_auto_charge_enable_out(fauto), .power_switch_absent_out(absent),
        .auto_charge_disable_bit_out(adis));
    task chk1(input string nm, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task chkv(input string nm, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    // Straps must sit still from release until the sampling edge.
    task boot(input logic [4:0] s);
        @(posedge clk_sys_in);
        strap <= s;
        sys_rst_in <= 1;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 0;
        cyc(8);
    endtask
    task reg_wr(input logic [3:0] m, input logic [3:0] d);
        @(posedge clk_sys_in);
        wr <= m;
        wd <= d;
        @(posedge clk_sys_in);
        wr <= 4'h0;
        cyc(2);
    endtask
    task t_i2c;
        boot(5'h18);
        chk1("mode", 1'b1, i2c);
        @(posedge clk_sys_in);
        req <= 4'h5;
        sts <= 1;
        strap <= 5'h1e;
        reg_wr(4'h1, 4'h1);
        cyc(3);
        chkv("power", 4'h5, psw);
        chk1("bb enable", 1'b1, billboard_enable_pin);
        chkv("field", 4'h1, {2'h0, fld});
        chk1("ganged", 1'b0, gang);
        chkv("oe", 4'h0, {1'h0, oe});
    endtask
    task t_smbus;
        @(posedge clk_sys_in);
        sts <= 0;
        boot(5'h07);
        chk1("mode", 1'b0, i2c);
        chk1("ganged", 1'b1, gang);
        chk1("switch absent", 1'b1, absent);
        chk1("auto disable", 1'b1, adis);
        chk1("bb enable", 1'b0, billboard_enable_pin);
        chkv("field", 4'h2, {2'h0, fld});
        chkv("power", 4'ha, psw);
        chk1("full auto", 1'b0, fauto);
        chkv("oe", 4'h0, {1'h0, oe});
        reg_wr(4'h1, 4'h0);
        chk1("ganged", 1'b0, gang);
        @(posedge clk_sys_in);
        sts <= 1;
        up <= 3'h5;
        cyc(3);
        chkv("oe", 4'h7, {1'h0, oe});
        chkv("indicators", 4'h5, {1'h0, drv});
        @(posedge clk_sys_in);
        up <= 3'h2;
        cyc(3);
        chkv("indicators", 4'h2, {1'h0, drv});
    endtask
    task t_charge;
        @(posedge clk_sys_in);
        sts <= 0;
        chg <= 1;
        rbb <= 1;
        boot(5'h00);
        chk1("full auto", 1'b1, fauto);
        chk1("auto disable", 1'b0, adis);
        chk1("switch absent", 1'b0, absent);
        chk1("ganged", 1'b0, gang);
        chk1("bb enable", 1'b1, billboard_enable_pin);
        reg_wr(4'he, 4'hc);
        chk1("full auto", 1'b0, fauto);
        chk1("switch absent", 1'b1, absent);
        chk1("auto disable", 1'b1, adis);
        chk1("ganged", 1'b0, gang);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_in);
        t_i2c();
        t_smbus();
        t_charge();
        finish_test();
    end
    initial begin
        #20000;
        n_mismatch++;
        finish_test();
    end
endmodule // testbench
